/* File: include/hlf_pkg.sv */
package hlf_pkg;

  // ----------------------------------------------------------------
  // Link field sizes and markers
  // ----------------------------------------------------------------
  localparam int unsigned CMD_BITS     = 32;
  localparam int unsigned RESP_BITS    = 36;
  localparam int unsigned TAG_BITS     = 4;
  localparam int unsigned LEN_BITS     = 6;
  localparam int unsigned CAD_HI       = 31;
  localparam int unsigned CAD_LO       = 28;
  localparam int unsigned VERB_HI      = 19;
  localparam int unsigned VERB_LO      = 8;
  localparam logic [2:0]  MARK_BITS    = 3'h4;
  localparam logic [2:0]  HI_SAT       = 3'h7;
  localparam logic [3:0]  TAG_PREAMBLE = 4'hA;
  localparam logic [9:0]  CAD_FIRST    = 10'h001;
  localparam logic [9:0]  CAD_LAST     = 10'h004;
  localparam logic [11:0] RESET_VERB   = 12'h7FF;
  localparam logic [10:0] SCNT_MAX     = 11'h7FF;
  localparam logic [9:0]  RCNT_MAX     = 10'h3FF;

  // ----------------------------------------------------------------
  // Fractional-rate cadence
  // ----------------------------------------------------------------
  localparam logic [3:0]  RUN_LAST     = 4'hC;
  localparam logic [3:0]  RUN_LONG     = 4'hC;
  localparam logic [3:0]  RUN_SHORT    = 4'hB;

  typedef enum logic [2:0] {ST_WAIT, ST_REQ, ST_TURN, ST_ADDR, ST_NORMAL} hlf_link_st_t;
  typedef enum logic [2:0] {PH_IDLE, PH_RESP, PH_TAG, PH_LEN, PH_DATA, PH_PAD} hlf_phase_t;
  typedef enum logic [3:0] {
    RATE_48K, RATE_8K, RATE_12K, RATE_16K, RATE_32K, RATE_96K, RATE_192K,
    RATE_11K025, RATE_22K05, RATE_44K1, RATE_88K2, RATE_176K4
  } hlf_rate_t;

  typedef struct packed {
    logic       tx_en;
    logic [3:0] tx_tag;
    hlf_rate_t  rate;
    logic [3:0] rx_tag;
  } hlf_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } hlf_word_t;

  typedef struct packed {
    logic [1:0]   bclk_s;
    logic [1:0]   sync_s;
    logic [1:0]   sdo_s;
    logic [1:0]   rstn_s;
    logic [1:0]   sdi_s;
    logic         bclk_d;
    hlf_link_st_t st;
    hlf_phase_t   ph;
    logic [2:0]   hi_cnt;
    logic [7:0]   sync_sh;
    logic [9:0]   rcnt;
    logic [10:0]  scnt;
    logic [31:0]  cmd_sh;
    logic         cmd_pend;
    hlf_word_t    cmd;
    logic [3:0]   cad;
    logic [35:0]  out_sh;
    logic [5:0]   bits_left;
    logic [2:0]   blk_left;
    logic [2:0]   nblk;
    logic         rx_on;
    logic [31:0]  rx_sh;
    logic [5:0]   rx_cnt;
    hlf_word_t    rx;
    logic [2:0]   frm_cnt;
    logic [3:0]   run_idx;
    logic [3:0]   fill_cnt;
    logic         sdi;
    logic         sdi_oe;
    logic         pop;
    logic         up;
  } hlf_state_t;

  localparam hlf_state_t RST_STATE = '0;

  function automatic logic [3:0] hlf_run_len(input logic [3:0] idx);
    return (idx == 4'h0 || idx == 4'h3 || idx == 4'h6 || idx == 4'h9) ? RUN_LONG : RUN_SHORT;
  endfunction : hlf_run_len

endpackage : hlf_pkg

/* File: hdl/hlf_link_frame.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Sample FIFO
// ------------------------------------------------------------------
module hlf_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       in_valid_i,
  input  wire logic [WIDTH-1:0]           in_data_i,
  output logic                            in_ready_o,
  output logic                            out_valid_o,
  output logic [WIDTH-1:0]                out_data_o,
  input  wire logic                       out_ready_i,
  output logic [$clog2(DEPTH):0]          level_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
    logic          rdy;
  } hlf_fifo_st_t;

  if (DEPTH < 2 || WIDTH < 1) begin : g_chk
    $error("hlf_fifo: depth below two or zero width");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  hlf_fifo_st_t     f_reg;
  hlf_fifo_st_t     f_next;
  logic             push;
  logic             pull;

  assign push        = in_valid_i && f_reg.rdy;
  assign pull        = out_ready_i && (f_reg.cnt != '0);
  assign in_ready_o  = f_reg.rdy;
  assign out_valid_o = (f_reg.cnt != '0);
  assign out_data_o  = mem[f_reg.rd];
  assign level_o     = f_reg.cnt;

  always_comb begin
    f_next = f_reg;
    if (push) begin
      f_next.wr = (f_reg.wr == AW'(DEPTH - 1)) ? '0 : AW'(f_reg.wr + 1'b1);
    end
    if (pull) begin
      f_next.rd = (f_reg.rd == AW'(DEPTH - 1)) ? '0 : AW'(f_reg.rd + 1'b1);
    end
    f_next.cnt = (AW + 1)'(f_reg.cnt + push - pull);
    // Ready is registered so the producer never sees a combinational path.
    f_next.rdy = (f_next.cnt < (AW + 1)'(DEPTH));
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      f_reg <= '{wr: '0, rd: '0, cnt: '0, rdy: 1'b1};
    end else begin
      f_reg <= f_next;
    end
    if (push) begin
      mem[f_reg.wr] <= in_data_i;
    end
  end

endmodule : hlf_fifo

module hlf_link_frame #(
  parameter int unsigned SAMPLE_BITS = 20,
  parameter int unsigned FIFO_DEPTH  = 32
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             link_bclk_i,
  input  wire logic             link_sync_i,
  input  wire logic             link_sdo_i,
  input  wire logic             link_rst_n_i,
  input  wire logic             link_sdi_i,
  output logic                  link_sdi_o,
  output logic                  link_sdi_oe_o,
  input  wire hlf_pkg::hlf_cfg_t cfg_i,
  input  wire logic [31:0]      resp_i,
  input  wire logic             smp_valid_i,
  input  wire logic [31:0]      smp_data_i,
  output logic                  smp_ready_o,
  output hlf_pkg::hlf_word_t    cmd_o,
  output hlf_pkg::hlf_word_t    rx_o,
  output logic [3:0]            cad_o,
  output logic                  link_up_o
);
  import hlf_pkg::*;

  if (SAMPLE_BITS < 1 || SAMPLE_BITS > 32 || FIFO_DEPTH < 4) begin : g_chk
    $error("hlf_link_frame: sample width outside 1..32 or fifo too shallow");
  end

  localparam int unsigned SHIFT = 32 - SAMPLE_BITS;

  hlf_state_t        r_reg;
  hlf_state_t        r_next;
  logic              rise;
  logic              fall;
  logic              fstart;
  logic              mlast;
  logic              nonempty;
  logic [2:0]        cad_blk;
  logic [2:0]        cad_mod;
  logic              fifo_valid;
  logic [31:0]       fifo_data;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;

  function automatic logic [2:0] pad_of(input logic [2:0] nb);
    return 3'(8 - ((int'(nb) * SAMPLE_BITS) % 8));
  endfunction : pad_of

  function automatic logic [5:0] bytes_of(input logic [2:0] nb);
    return 6'((int'(nb) * SAMPLE_BITS + 7) / 8);
  endfunction : bytes_of

  // ----------------------------------------------------------------
  // Edge and marker detection on the sampled link clock
  // ----------------------------------------------------------------
  assign rise   = r_reg.bclk_s[1] && !r_reg.bclk_d;
  assign fall   = !r_reg.bclk_s[1] && r_reg.bclk_d;
  assign fstart = rise && !r_reg.sync_s[1] && (r_reg.hi_cnt == MARK_BITS);
  assign mlast  = rise && r_reg.sync_s[1] && (r_reg.hi_cnt == MARK_BITS - 3'h1);

  // ----------------------------------------------------------------
  // Per-frame block count
  // ----------------------------------------------------------------
  assign nonempty = (r_reg.fill_cnt != hlf_run_len(r_reg.run_idx));

  always_comb begin
    cad_mod = 3'h1;
    cad_blk = 3'h1;
    case (cfg_i.rate)
      RATE_8K:     cad_mod = 3'h6;
      RATE_12K:    cad_mod = 3'h4;
      RATE_16K:    cad_mod = 3'h3;
      RATE_32K:    cad_mod = 3'h3;
      RATE_11K025: cad_mod = 3'h4;
      RATE_22K05:  cad_mod = 3'h2;
      default:     cad_mod = 3'h1;
    endcase
    case (cfg_i.rate)
      RATE_32K, RATE_96K, RATE_88K2: cad_blk = 3'h2;
      RATE_192K, RATE_176K4:         cad_blk = 3'h4;
      default:                       cad_blk = 3'h1;
    endcase
    if (r_reg.frm_cnt != 3'h0) begin
      cad_blk = 3'h0;
    end
    if (cfg_i.rate >= RATE_11K025 && !nonempty) begin
      cad_blk = 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic        sdo_v;
    logic [10:0] sc;
    logic [31:0] word;
    logic [7:0]  tagw;
    logic        drive;
    logic        ld;
    logic [35:0] ld_w;
    logic [5:0]  ld_n;
    sdo_v = r_reg.sdo_s[1];
    sc    = fstart ? 11'h000 : r_reg.scnt;
    word  = {r_reg.cmd_sh[30:0], sdo_v};
    tagw  = {r_reg.sync_sh[6:0], r_reg.sync_s[1]};
    drive = fstart ? (r_reg.st == ST_ADDR || r_reg.st == ST_NORMAL) : (r_reg.st == ST_NORMAL);
    ld    = 1'b0;
    ld_w  = '0;
    ld_n  = 6'h01;

    r_next           = r_reg;
    r_next.cmd.valid = 1'b0;
    r_next.rx.valid  = 1'b0;
    r_next.pop       = 1'b0;
    // Streams are heard on the outbound data line only; the inbound line is sampled for the address, and a second outbound line never exists here.
    r_next.bclk_s = {r_reg.bclk_s[0], link_bclk_i};
    r_next.sync_s = {r_reg.sync_s[0], link_sync_i};
    r_next.sdo_s  = {r_reg.sdo_s[0], link_sdo_i};
    r_next.rstn_s = {r_reg.rstn_s[0], link_rst_n_i};
    r_next.sdi_s  = {r_reg.sdi_s[0], link_sdi_i};
    r_next.bclk_d = r_reg.bclk_s[1];

    if (rise) begin
      r_next.hi_cnt  = r_reg.sync_s[1] ? ((r_reg.hi_cnt == HI_SAT) ? HI_SAT : r_reg.hi_cnt + 3'h1)
                                       : 3'h0;
      r_next.sync_sh = tagw;
      r_next.rcnt    = fstart ? 10'h000 : ((r_reg.rcnt == RCNT_MAX) ? RCNT_MAX
                                                                    : r_reg.rcnt + 10'h001);
      if (tagw[7:4] == TAG_PREAMBLE && r_reg.up) begin
        r_next.rx_on   = (tagw[3:0] == cfg_i.rx_tag);
        r_next.rx_cnt  = 6'h00;
        r_next.rx_sh   = '0;
        r_next.sync_sh = 8'h00;
      end
    end

    // Outbound line: one bit per clock edge, command first.
    if (rise || fall) begin
      r_next.scnt = (sc == SCNT_MAX) ? SCNT_MAX : sc + 11'h001;
      if (sc < 11'(CMD_BITS)) begin
        r_next.cmd_sh = word;
        if (sc == 11'(CMD_BITS - 1) && r_reg.up) begin
          r_next.cmd      = '{valid: 1'b1, data: word};
          r_next.cmd_pend = 1'b1;
          if (word[CAD_HI:CAD_LO] == r_reg.cad && word[VERB_HI:VERB_LO] == RESET_VERB) begin
            r_next.st       = ST_REQ;
            r_next.up       = 1'b0;
            r_next.ph       = PH_IDLE;
            r_next.nblk     = 3'h0;
            r_next.cmd_pend = 1'b0;
            r_next.cad      = 4'h0;
            r_next.sdi      = 1'b0;
          end
        end
      end else if (r_reg.rx_on && !fstart) begin
        r_next.rx_sh  = {r_reg.rx_sh[30:0], sdo_v};
        r_next.rx_cnt = r_reg.rx_cnt + 6'h01;
        if (r_reg.rx_cnt == 6'(SAMPLE_BITS - 1)) begin
          r_next.rx     = '{valid: 1'b1, data: {r_reg.rx_sh[30:0], sdo_v}};
          r_next.rx_sh  = '0;
          r_next.rx_cnt = 6'h00;
        end
      end
    end
    if (fstart) begin
      r_next.rx_on = 1'b0;
    end

    // Address request and assignment.
    case (r_reg.st)
      ST_WAIT: begin
        if (fstart) begin
          r_next.st = ST_REQ;
        end
      end
      ST_REQ: begin
        if (mlast) begin
          r_next.sdi    = 1'b1;
          r_next.sdi_oe = 1'b1;
          r_next.st     = ST_TURN;
        end
      end
      ST_TURN: begin
        if (fstart) begin
          r_next.sdi    = 1'b0;
          r_next.sdi_oe = 1'b0;
          r_next.st     = ST_ADDR;
        end
      end
      ST_ADDR: begin
        // The controller owns the line now; sample mid-bit on the falling edge.
        if (fall && r_reg.rcnt >= CAD_FIRST && r_reg.rcnt <= CAD_LAST) begin
          r_next.cad = {r_reg.cad[2:0], r_reg.sdi_s[1]};
        end
        if (fstart) begin
          r_next.st = ST_NORMAL;
          r_next.up = 1'b1;
        end
      end
      default: ;
    endcase

    // Inbound frame: response, then at most one tagged stream.
    if (rise && drive) begin
      if (fstart) begin
        ld            = 1'b1;
        ld_w          = {r_reg.cmd_pend, 3'b000, resp_i};
        ld_n          = 6'(RESP_BITS);
        r_next.ph     = PH_RESP;
        r_next.sdi_oe = 1'b1;
        r_next.cmd_pend = 1'b0;
        r_next.nblk   = (cfg_i.tx_en && fifo_level >= cad_blk) ? cad_blk : 3'h0;
        r_next.frm_cnt = (r_reg.frm_cnt >= cad_mod - 3'h1) ? 3'h0 : r_reg.frm_cnt + 3'h1;
        if (!nonempty) begin
          r_next.fill_cnt = 4'h0;
          r_next.run_idx  = (r_reg.run_idx == RUN_LAST) ? 4'h0 : r_reg.run_idx + 4'h1;
        end else begin
          r_next.fill_cnt = r_reg.fill_cnt + 4'h1;
        end
      end else if (r_reg.bits_left != 6'h00) begin
        r_next.sdi       = r_reg.out_sh[35];
        r_next.out_sh    = {r_reg.out_sh[34:0], 1'b0};
        r_next.bits_left = r_reg.bits_left - 6'h01;
      end else begin
        r_next.sdi = 1'b0;
        r_next.ph  = PH_IDLE;
        case (r_reg.ph)
          PH_RESP: begin
            if (r_reg.nblk != 3'h0) begin
              ld        = 1'b1;
              ld_w      = {cfg_i.tx_tag, 32'h0000_0000};
              ld_n      = 6'(TAG_BITS);
              r_next.ph = PH_TAG;
            end
          end
          PH_TAG: begin
            ld        = 1'b1;
            ld_w      = {bytes_of(r_reg.nblk), 30'h0000_0000};
            ld_n      = 6'(LEN_BITS);
            r_next.ph = PH_LEN;
          end
          PH_LEN, PH_DATA: begin
            if (r_reg.ph == PH_LEN || r_reg.blk_left != 3'h0) begin
              ld              = 1'b1;
              ld_w            = {32'(fifo_data << SHIFT), 4'h0};
              ld_n            = 6'(SAMPLE_BITS);
              r_next.pop      = 1'b1;
              r_next.ph       = PH_DATA;
              r_next.blk_left = (r_reg.ph == PH_LEN) ? r_reg.nblk - 3'h1
                                                     : r_reg.blk_left - 3'h1;
            end else if (pad_of(r_reg.nblk) != 3'h0) begin
              ld        = 1'b1;
              ld_w      = '0;
              ld_n      = 6'(pad_of(r_reg.nblk));
              r_next.ph = PH_PAD;
            end
          end
          default: ;
        endcase
      end
      if (ld) begin
        r_next.sdi       = ld_w[35];
        r_next.out_sh    = {ld_w[34:0], 1'b0};
        r_next.bits_left = ld_n - 6'h01;
      end
    end

    if (!r_reg.rstn_s[1]) begin
      r_next        = RST_STATE;
      r_next.bclk_s = {r_reg.bclk_s[0], link_bclk_i};
      r_next.sync_s = {r_reg.sync_s[0], link_sync_i};
      r_next.sdo_s  = {r_reg.sdo_s[0], link_sdo_i};
      r_next.rstn_s = {r_reg.rstn_s[0], link_rst_n_i};
      r_next.sdi_s  = {r_reg.sdi_s[0], link_sdi_i};
      r_next.bclk_d = r_reg.bclk_s[1];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      r_reg <= RST_STATE;
    end else begin
      r_reg <= r_next;
    end
  end

  hlf_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (smp_valid_i),
    .in_data_i   (smp_data_i),
    .in_ready_o  (smp_ready_o),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (r_reg.pop),
    .level_o     (fifo_level)
  );

  // One inbound stream per frame always fits this line, so it is never split.
  assign link_sdi_o    = r_reg.sdi;
  assign link_sdi_oe_o = r_reg.sdi_oe;
  assign cmd_o         = r_reg.cmd;
  assign rx_o          = r_reg.rx;
  assign cad_o         = r_reg.cad;
  assign link_up_o     = r_reg.up;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req;
    (r_reg.st == ST_REQ) && mlast && r_reg.rstn_s[1];
  endsequence

  sequence s_addr_given;
    (r_reg.st == ST_TURN) && r_reg.sdi && r_reg.sdi_oe;
  endsequence

  a_sdo_both_edges: assert property ((rise || fall) && !fstart && r_reg.scnt < 11'h100
    && r_reg.rstn_s[1] |=> r_reg.scnt == $past(r_reg.scnt) + 11'h001)
    else $error("outbound bit count missed an edge");
  a_sdi_on_rise: assert property ($changed(r_reg.sdi) |-> $past(rise)
    || !$past(r_reg.rstn_s[1]) || $past(r_reg.cmd.valid == 1'b0 && r_next.st == ST_REQ))
    else $error("inbound bit changed away from a rising edge");
  a_link_reset: assert property (!r_reg.rstn_s[1] |=> r_reg.st == ST_WAIT && !r_reg.sdi_oe
    && !r_reg.up)
    else $error("link reset did not restore defaults");
  a_cmd_width: assert property (r_reg.cmd.valid |-> r_reg.scnt == 11'(CMD_BITS))
    else $error("command word not taken at bit 32");
  a_tag_start: assert property (rise && tagw_match() && r_reg.up && r_reg.rstn_s[1]
    |=> r_reg.rx_cnt == 6'h00 && r_reg.rx_sh == '0)
    else $error("stream capture not restarted at tag");
  a_resp_first: assert property (fstart && r_reg.st == ST_NORMAL && r_reg.rstn_s[1]
    |=> r_reg.ph == PH_RESP && r_reg.bits_left == 6'(RESP_BITS - 1))
    else $error("frame did not open with response field");
  a_hdr_len: assert property ($rose(r_reg.ph == PH_LEN) |-> $past(r_reg.ph) == PH_TAG
    && r_reg.bits_left == 6'(LEN_BITS - 1))
    else $error("stream header out of order");
  a_pad_need: assert property ($rose(r_reg.ph == PH_PAD) |-> pad_of(r_reg.nblk) != 3'h0)
    else $error("pad emitted on a byte boundary");
  a_rate_8k: assert property (cfg_i.rate == RATE_8K && r_reg.frm_cnt != 3'h0
    |-> cad_blk == 3'h0)
    else $error("8 kHz cadence sent a block off slot");
  a_run_bound: assert property (r_reg.run_idx <= RUN_LAST
    && r_reg.fill_cnt <= hlf_run_len(r_reg.run_idx))
    else $error("44.1 kHz run counter out of range");
  a_init_req: assert property (s_req |=> s_addr_given ##1 (r_reg.sdi [*3]))
    else $error("address request not held on the inbound line");
  a_resp_next: assert property (r_reg.cmd.valid && r_reg.st == ST_NORMAL
    |-> r_reg.cmd_pend)
    else $error("command taken without a pending answer");
  a_restart: assert property (fstart && r_reg.rstn_s[1] |=> r_reg.rcnt == 10'h000
    && r_reg.scnt == 11'h001)
    else $error("bit counters not restarted at frame start");

  function automatic logic tagw_match();
    return {r_reg.sync_sh[6:3]} == TAG_PREAMBLE;
  endfunction : tagw_match

endmodule : hlf_link_frame

/* File: verification/hlf_host_model.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Link controller model
// ------------------------------------------------------------------
module hlf_host_model #(
  parameter int FB = 250
) (
  output logic      bclk_o,
  output logic      sync_o,
  output logic      sdo_o,
  output logic      rst_n_o,
  output logic      sdi_o,
  output logic      sdi_oe_o,
  input  wire logic sdi_i
);
  // Frames are shorter than on a real link so that a run stays brief.
  logic [31:0]  cmd;
  logic [16:0]  smp;
  logic [7:0]   stag;
  logic [3:0]   tag, addr;
  logic         tag_on, req;
  logic [0:119] cur, last;
  int           frames, e;

  initial begin
    {bclk_o, sync_o, sdo_o, rst_n_o, sdi_o, sdi_oe_o, tag_on, req} = '0;
    {cmd, smp, tag, cur, last} = '0;
    addr   = 4'h5;
    frames = 0;
    #2000 rst_n_o = 1'b1;
    forever for (int b = 0; b < FB; b++) for (int h = 0; h < 2; h++) begin
      #20;
      e    = 2 * b + h;
      stag = {4'hA, tag};
      if (h == 0) begin
        // Each inbound bit is taken just before the next rising edge.
        if (b == 0) begin
          req  = sdi_i;
          last = cur;
          frames++;
        end else if (b <= 120) cur[b-1] = sdi_i;
        if (b == 5) req = 1'b0;
        sdi_oe_o = req && b >= 1 && b <= 4;
        sdi_o    = sdi_oe_o && addr[4-b];
        sync_o   = b >= FB - 4 || (tag_on && b >= 16 && b < 24 && stag[23-b]);
      end
      // Stream data follows on the edge right after the one that carries the last tag bit.
      sdo_o = e < 32 ? cmd[31-e] : tag_on && e >= 47 && e < 64 && smp[63-e];
      #20 bclk_o = ~bclk_o;
    end
  end
endmodule : hlf_host_model

/* File: verification/testbench.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Frame interface bench
// ------------------------------------------------------------------
module testbench;
  import hlf_pkg::*;

  logic        core_clk_i  = 1'b0;
  logic        rst_i       = 1'b1;
  logic        smp_valid_i = 1'b0;
  logic [31:0] resp_i      = 32'h0;
  hlf_cfg_t    cfg_i       = '0;
  logic        bclk, sync, sdo, rst_n, h_sdi, h_oe, d_sdi, d_oe, smp_ready_o, link_up_o;
  hlf_word_t   cmd_o, rx_o;
  logic [3:0]  cad_o;
  int          miscompares = 0;
  int          n_checks    = 0;
  // The weak pull-down wins whenever neither side drives the line.
  wire         link_sdi = d_oe ? d_sdi : h_oe && h_sdi;

  always #5 core_clk_i = ~core_clk_i;

  hlf_host_model i_host (.bclk_o(bclk), .sync_o(sync), .sdo_o(sdo), .rst_n_o(rst_n),
                         .sdi_o(h_sdi), .sdi_oe_o(h_oe), .sdi_i(link_sdi));

  hlf_link_frame #(.SAMPLE_BITS(17), .FIFO_DEPTH(32)) i_dut (
    .core_clk_i, .rst_i, .link_bclk_i(bclk), .link_sync_i(sync), .link_sdo_i(sdo),
    .link_rst_n_i(rst_n), .link_sdi_i(link_sdi), .link_sdi_o(d_sdi), .link_sdi_oe_o(d_oe),
    .cfg_i, .resp_i, .smp_valid_i, .smp_data_i(32'hFFF5A5A5), .smp_ready_o, .cmd_o,
    .rx_o, .cad_o, .link_up_o);

  task automatic tally_and_finish();
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(string nm, logic [67:0] exp, logic [67:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic frames(int n);
    int f0;
    f0 = i_host.frames;
    for (int i = 0; i < 2100 * n && i_host.frames < f0 + n; i++) @(negedge core_clk_i);
    if (i_host.frames < f0 + n) begin
      miscompares++;
      tally_and_finish();
    end
    // The host counts a frame just before its first edge, and the codec sees that edge only
    // after its pin synchronisers, so give the frame start time to take effect.
    repeat (8) @(negedge core_clk_i);
  endtask : frames

  // Pulses are looked at on the falling edge, where they have settled.
  task automatic wait_for(int sel);
    for (int i = 0; i < 2500; i++) begin
      @(negedge core_clk_i);
      if (sel == 0 ? cmd_o.valid === 1'b1 : sel == 1 ? rx_o.valid === 1'b1 :
          link_up_o === 1'b0) return;
    end
    miscompares++;
    tally_and_finish();
  endtask : wait_for

  task automatic t_init();
    frames(4);
    chk("link_up", 1, link_up_o);
    chk("cad", 4'h5, cad_o);
  endtask : t_init

  task automatic t_cmd();
    resp_i     = 32'hC0DE1234;
    i_host.cmd = 32'h51234567;
    frames(1);
    wait_for(0);
    chk("cmd", 32'h51234567, cmd_o.data);
    frames(2);
    chk("resp", {4'h8, 32'hC0DE1234}, i_host.last[0:35]);
  endtask : t_cmd

  task automatic t_codec_rst();
    i_host.cmd = 32'h5007FF00;
    frames(1);
    wait_for(2);
    chk("cad_clr", 4'h0, cad_o);
    i_host.cmd = 32'h0;
    frames(4);
    chk("relink", 1, link_up_o);
  endtask : t_codec_rst

  task automatic t_link_rst();
    i_host.addr    = 4'h9;
    i_host.rst_n_o = 1'b0;
    repeat (10) @(negedge core_clk_i);
    chk("rst_up", 0, link_up_o);
    i_host.rst_n_o = 1'b1;
    frames(4);
    chk("cad_new", 4'h9, cad_o);
  endtask : t_link_rst

  // The buffer is filled while sending is off, then drained at four blocks a frame.
  task automatic t_stream();
    cfg_i       = {1'b0, 4'h3, RATE_192K, 4'h6};
    smp_valid_i = 1'b1;
    repeat (40) @(negedge core_clk_i);
    chk("full", 0, smp_ready_o);
    smp_valid_i   = 1'b0;
    i_host.tag    = 4'h6;
    i_host.smp    = 17'h0B00F;
    i_host.tag_on = 1'b1;
    cfg_i.tx_en   = 1'b1;
    frames(1);
    wait_for(1);
    chk("rx", 17'h0B00F, rx_o.data);
    frames(2);
    chk("tag", 4'h3, i_host.last[36:39]);
    chk("len", 6'h09, i_host.last[40:45]);
    chk("blk", {4{17'h1A5A5}}, i_host.last[46:113]);
    chk("pad", 4'h0, i_host.last[114:117]);
    frames(8);
    chk("empty", 10'h0, i_host.last[36:45]);
    chk("room", 1, smp_ready_o);
  endtask : t_stream

  initial begin
    repeat (8) @(negedge core_clk_i);
    rst_i = 1'b0;
    t_init();
    t_cmd();
    t_codec_rst();
    t_link_rst();
    t_stream();
    tally_and_finish();
  end
endmodule : testbench
